// file: design/sfl_pkg.sv
package sfl_pkg;

   // one protocol at a time; quad wins a volatile tie
   typedef enum logic [1:0] {
      SFL_EXTENDED,
      SFL_DUAL,
      SFL_QUAD
   } sfl_protocol_t;

   // enhanced volatile config field positions (cleared bit = feature on)
   localparam int SFL_EVC_BOOST_N_BIT = 3;
   localparam int SFL_EVC_DUAL_N_BIT  = 6;
   localparam int SFL_EVC_QUAD_N_BIT  = 7;
   // nonvolatile config field positions
   localparam int SFL_NVC_DUAL_N_BIT  = 2;
   localparam int SFL_NVC_QUAD_N_BIT  = 3;

   // reset value: boost disabled, extended protocol
   localparam logic [7:0] SFL_EVC_RESET = 8'hff;

   // lane counts per serial clock
   localparam logic [2:0] SFL_LANES_1 = 3'h1;
   localparam logic [2:0] SFL_LANES_2 = 3'h2;
   localparam logic [2:0] SFL_LANES_4 = 3'h4;
   localparam logic [3:0] SFL_BITS_PER_BYTE = 4'h8;

   // boost supply wait after last data in (longest time: rounds down)
   localparam int SFL_CLOCK_HZ      = 100_000_000;
   localparam int SFL_BOOST_WAIT_MS = 200;
   localparam int SFL_BOOST_WAIT_CYCLES = (SFL_CLOCK_HZ / 1000) * SFL_BOOST_WAIT_MS;

endpackage

// file: design/sfl_sync.sv
`timescale 1ns/1ps

// two-flop synchroniser, one per bit
module sfl_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             clock_enable,
   // bits from another domain
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;   // first stage, read only by q

   // both stages freeze with the clock enable
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q    <= '0;
      end else if (clock_enable) begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// file: design/sfl_lane_select.sv
`timescale 1ns/1ps

// Summary of operation
// R01: extended single/dual: low pin freezes protection
// R02: quad reads and quad protocol use lane 2
// R03: boost acceleration only when config bit cleared
// R04: lane stays data; boost window 200 ms
// R05: boost acceleration disabled after reset
// R06: sample rising edge, drive from falling edge
// R07: master uses clock mode 0 or 3
// R08: deselected device releases its outputs
// R09: exactly one protocol, never mixed
// R10: extended: instruction on lane 0 only
// R11: dual protocol: every phase on two lanes
// R12: volatile dual bit selects dual until power-on
// R13: nonvolatile dual bit selects dual at power-on
// R14: quad protocol: every phase on four lanes
// R15: boosted quad run falls back to extended
// R16: quad selected disables protect and pause
// R17: volatile quad bit selects quad until power-on
// R18: nonvolatile quad bit selects quad at power-on
// R19: master drops select before first instruction
// R20: volatile quad beats volatile dual
module sfl_lane_select
   import sfl_pkg::*;
#(
   parameter int BOOST_WAIT_CYCLES = sfl_pkg::SFL_BOOST_WAIT_CYCLES
) (
   // system clock domain
   input  wire logic                   clock,
   input  wire logic                   rst,
   input  wire logic                   clock_enable,
   // serial link pins
   input  wire logic                   spi_clk,
   input  wire logic                   chip_select_n,
   input  wire logic [3:0]             lane_in,
   output logic      [3:0]             lane_out,
   output logic      [3:0]             lane_oe,
   input  wire logic                   boost_supply_high,
   // configuration
   input  wire logic [15:0]            nonvolatile_config,
   input  wire logic                   evcr_write,
   input  wire logic [7:0]             evcr_data,
   output logic      [7:0]             enhanced_volatile_config,
   // instruction context from the decoder
   input  wire logic [2:0]             data_lane_count,
   input  wire logic                   quad_output_read_cmd,
   input  wire logic                   quad_io_read_cmd,
   input  wire logic                   quad_input_program_cmd,
   input  wire logic                   quad_input_ext_program_cmd,
   input  wire logic                   quad_modify_cmd,
   input  wire logic                   last_data_in,
   input  wire logic                   write_in_progress_flag,
   // transmit data
   input  wire logic                   tx_active,
   input  wire logic [7:0]             tx_byte,
   output logic                        tx_taken,
   // receive data
   output logic      [7:0]             rx_byte,
   output logic                        rx_valid,
   output logic                        rx_is_instr,
   // status
   output sfl_pkg::sfl_protocol_t      protocol,
   output logic                        protect_freeze,
   output logic                        pause_enable,
   output logic                        lane2_is_data,
   output logic                        op_start,
   output logic                        op_boosted
);

   // ---------------- link domain ----------------
   logic [3:0] link_sample;     // lanes caught on the rising edge
   logic       link_toggle;     // flips once per rising edge while selected
   logic [3:0] tx_bits;         // core-side bits for the next falling edge
   logic [3:0] drive_oe;        // core-side lane enables
   logic       link_clear;      // deselect or system reset

   assign link_clear = chip_select_n | rst;

   // rising edge: sample lanes, announce by toggle; hold stays stable one period
   always_ff @(posedge spi_clk or posedge rst) begin
      if (rst) begin
         link_sample <= 4'h0;
         link_toggle <= 1'b0;
      end else if (!chip_select_n) begin
         link_sample <= lane_in;               // [R06]
         link_toggle <= ~link_toggle;
      end
   end

   // falling edge launches data; deselect releases the lines at once
   always_ff @(negedge spi_clk or posedge link_clear) begin
      if (link_clear) begin
         lane_out <= 4'h0;
         lane_oe  <= 4'h0;                     // [R08]
      end else begin
         lane_out <= tx_bits;                  // [R06]
         lane_oe  <= drive_oe;
      end
   end

   // ---------------- crossings into the core ----------------
   logic [3:0] sync_q;          // selected, boost, lane 2 level, toggle
   logic       selected;
   logic       boost_on;
   logic       lane2_level;
   logic       toggle_seen;     // last toggle value handled
   logic       sample_event;

   sfl_sync #(
      .WIDTH (4)
   ) u_sync (
      .clock        (clock),
      .rst          (rst),
      .clock_enable (clock_enable),
      .d            ({~chip_select_n, boost_supply_high, lane_in[2], link_toggle}),
      .q            (sync_q)
   );

   assign selected     = sync_q[3];
   assign boost_on     = sync_q[2];
   assign lane2_level  = sync_q[1];
   assign sample_event = (sync_q[0] != toggle_seen) && selected;

   // edge detect on the synchronised toggle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         toggle_seen <= 1'b0;
      end else if (clock_enable) begin
         toggle_seen <= sync_q[0];
      end
   end

   // ---------------- configuration ----------------
   logic por_pending;           // first enabled cycle after reset

   // volatile copy takes the power-on protocol from the nonvolatile bits
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         por_pending              <= 1'b1;
         enhanced_volatile_config <= SFL_EVC_RESET;   // [R05]
      end else if (clock_enable) begin
         if (por_pending) begin
            por_pending <= 1'b0;
            // power-on discards any volatile protocol choice
            enhanced_volatile_config[SFL_EVC_QUAD_N_BIT] <=
               nonvolatile_config[SFL_NVC_QUAD_N_BIT];  // [R18] [R12] [R17]
            enhanced_volatile_config[SFL_EVC_DUAL_N_BIT] <=
               nonvolatile_config[SFL_NVC_DUAL_N_BIT];  // [R13]
         end else if (evcr_write) begin
            enhanced_volatile_config <= evcr_data;      // [R12] [R17] [R03]
         end
      end
   end

   // ---------------- protocol choice ----------------
   sfl_protocol_t next_protocol;

   always_comb begin
      if (!enhanced_volatile_config[SFL_EVC_QUAD_N_BIT]) begin
         next_protocol = SFL_QUAD;             // [R17] [R20]
      end else if (!enhanced_volatile_config[SFL_EVC_DUAL_N_BIT]) begin
         next_protocol = SFL_DUAL;             // [R12]
      end else begin
         next_protocol = SFL_EXTENDED;
      end
      // boosted quad run: extended so polling and suspend work
      if (next_protocol == SFL_QUAD && write_in_progress_flag && boost_on) begin
         next_protocol = SFL_EXTENDED;         // [R15]
      end
   end

   // switch only while deselected so a frame never mixes protocols;
   // a write is complete once select has risen
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         protocol <= SFL_EXTENDED;
      end else if (clock_enable && !selected && !por_pending) begin
         protocol <= next_protocol;            // [R09]
      end
   end

   // ---------------- frame: lane width and bit assembly ----------------
   logic       instr_phase;     // first byte of the frame
   logic [3:0] rx_cnt;          // bits gathered in the current byte
   logic [7:0] rx_shift;
   logic [3:0] tx_cnt;          // bits sent from the current byte
   logic [7:0] tx_shift;
   logic [2:0] width;           // lanes in use for this clock
   logic [7:0] next_rx;
   logic [3:0] next_rx_cnt;
   logic [7:0] next_tx;
   logic [3:0] next_tx_bits;
   logic [3:0] next_oe;

   // lanes per clock from protocol and phase
   always_comb begin
      case (protocol)
         SFL_DUAL: width = SFL_LANES_2;                   // [R11]
         SFL_QUAD: width = SFL_LANES_4;                   // [R14]
         SFL_EXTENDED: begin
            // instruction on lane 0, then what the instruction asks
            width = instr_phase ? SFL_LANES_1 : data_lane_count;   // [R10]
         end
         default: width = SFL_LANES_1;
      endcase
   end

   // shift the sampled lanes in, and the next lanes out
   always_comb begin
      next_rx      = rx_shift;
      next_tx      = (tx_cnt == 4'h0) ? tx_byte : tx_shift;
      next_tx_bits = 4'h0;
      next_oe      = 4'h0;
      case (width)
         SFL_LANES_2: begin
            next_rx      = {rx_shift[5:0], link_sample[1:0]};
            next_tx_bits = {2'h0, next_tx[7:6]};
            next_oe      = 4'h3;
         end
         SFL_LANES_4: begin
            next_rx      = {rx_shift[3:0], link_sample};
            next_tx_bits = next_tx[7:4];
            next_oe      = 4'hf;
         end
         default: begin
            // single lane: in on lane 0, out on lane 1
            next_rx      = {rx_shift[6:0], link_sample[0]};
            next_tx_bits = {2'h0, next_tx[7], 1'b0};
            next_oe      = 4'h2;
         end
      endcase
      next_rx_cnt = rx_cnt + {1'b0, width};
   end

   // receive side: one byte every eight bits; deselect restarts the frame
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         instr_phase <= 1'b1;
         rx_cnt      <= 4'h0;
         rx_shift    <= 8'h00;
         rx_byte     <= 8'h00;
         rx_valid    <= 1'b0;
         rx_is_instr <= 1'b0;
      end else if (clock_enable) begin
         rx_valid <= 1'b0;
         if (!selected) begin
            instr_phase <= 1'b1;               // [R19]
            rx_cnt      <= 4'h0;
         end else if (sample_event && !tx_active) begin
            rx_shift <= next_rx;
            if (next_rx_cnt >= SFL_BITS_PER_BYTE) begin
               rx_cnt      <= 4'h0;
               rx_byte     <= next_rx;
               rx_valid    <= 1'b1;
               rx_is_instr <= instr_phase;
               instr_phase <= 1'b0;
            end else begin
               rx_cnt <= next_rx_cnt;
            end
         end
      end
   end

   // transmit side: bits prepared right after each rising edge;
   // needs the serial half period longer than the crossing delay
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_cnt   <= 4'h0;
         tx_shift <= 8'h00;
         tx_bits  <= 4'h0;
         drive_oe <= 4'h0;
         tx_taken <= 1'b0;
      end else if (clock_enable) begin
         tx_taken <= 1'b0;
         if (!selected || !tx_active) begin
            tx_cnt   <= 4'h0;
            drive_oe <= 4'h0;                  // [R08]
         end else if (sample_event) begin
            tx_bits  <= next_tx_bits;
            drive_oe <= next_oe;
            tx_shift <= next_tx << width;
            tx_taken <= (tx_cnt == 4'h0);
            tx_cnt   <= (tx_cnt + {1'b0, width}) & 4'h7;
         end
      end
   end

   // ---------------- pin functions ----------------
   logic quad_cmd;              // extended-protocol quad instruction active
   logic quad_selected;

   assign quad_cmd = quad_output_read_cmd | quad_io_read_cmd |
                     quad_input_program_cmd | quad_input_ext_program_cmd;
   assign quad_selected = (protocol == SFL_QUAD) && selected;

   // lane 2 role, protect freeze and pause enable
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lane2_is_data  <= 1'b0;
         protect_freeze <= 1'b0;
         pause_enable   <= 1'b1;
      end else if (clock_enable) begin
         // data lane for quad reads, quad programs (until deselect) and quad protocol
         lane2_is_data <= quad_selected || (selected && quad_cmd);   // [R02] [R04]
         // low logic level freezes the area; boost level is a supply, not control
         protect_freeze <= !lane2_level && !boost_on &&
                           !quad_selected &&                          // [R16]
                           !((protocol == SFL_EXTENDED) && quad_cmd); // [R01]
         pause_enable <= !quad_selected;                              // [R16]
      end
   end

   // ---------------- boost supply window ----------------
   logic        boost_wait;     // waiting for the supply to rise
   logic [31:0] wait_cnt;
   logic        boost_allowed;

   assign boost_allowed = !enhanced_volatile_config[SFL_EVC_BOOST_N_BIT];   // [R03]

   // start the program/erase boosted if the supply rises in time
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         boost_wait <= 1'b0;
         wait_cnt   <= 32'h0;
         op_start   <= 1'b0;
         op_boosted <= 1'b0;
      end else if (clock_enable) begin
         op_start <= 1'b0;
         if (last_data_in && (quad_cmd || quad_modify_cmd)) begin
            if (boost_allowed) begin
               boost_wait <= 1'b1;             // [R04]
               wait_cnt   <= 32'h0;
            end else begin
               op_start   <= 1'b1;             // [R03]
               op_boosted <= 1'b0;
            end
         end else if (last_data_in) begin
            op_start   <= 1'b1;
            op_boosted <= 1'b0;
         end else if (boost_wait) begin
            if (boost_on) begin
               boost_wait <= 1'b0;
               op_start   <= 1'b1;
               op_boosted <= 1'b1;             // [R04]
            end else if (wait_cnt == 32'(BOOST_WAIT_CYCLES - 1)) begin
               // window missed: standard speed
               boost_wait <= 1'b0;
               op_start   <= 1'b1;
               op_boosted <= 1'b0;             // [R04]
            end else begin
               wait_cnt <= wait_cnt + 32'h1;
            end
         end
      end
   end

endmodule

// file: verification/sfl_lane_select_asserts.sv
`timescale 1ns/1ps

// port checker for the lane select block, core clock only
module sfl_lane_select_asserts
   import sfl_pkg::*;
(
   // core clock
   input wire logic                   clock,
   input wire logic                   rst,
   input wire logic                   clock_enable,
   // pins and config
   input wire logic                   chip_select_n,
   input wire logic [3:0]             lane_oe,
   input wire logic                   boost_supply_high,
   input wire logic                   evcr_write,
   input wire logic [7:0]             evcr_data,
   input wire logic [7:0]             enhanced_volatile_config,
   input wire logic                   last_data_in,
   // status
   input wire logic                   rx_valid,
   input wire sfl_pkg::sfl_protocol_t protocol,
   input wire logic                   pause_enable,
   input wire logic                   protect_freeze,
   input wire logic                   lane2_is_data,
   input wire logic                   op_start,
   input wire logic                   op_boosted
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   logic started; // writes in the nonvolatile_config load cycle are ignored, so skip it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         started <= 1'b0;
      end else if (clock_enable) begin
         started <= 1'b1;
      end
   end

   evcr_load_a: assert property (started && clock_enable && evcr_write |=>
      enhanced_volatile_config == $past(evcr_data)) else $error("evcr not loaded");
   quad_sel_a: assert property ((chip_select_n && clock_enable && !boost_supply_high
      && !enhanced_volatile_config[7])[*8] |=> protocol == SFL_QUAD) else $error("no quad");
   dual_sel_a: assert property ((chip_select_n && clock_enable
      && enhanced_volatile_config[7:6] == 2'b10)[*8] |=> protocol == SFL_DUAL)
      else $error("no dual");
   ext_sel_a: assert property ((chip_select_n && clock_enable
      && enhanced_volatile_config[7:6] == 2'b11)[*8] |=> protocol == SFL_EXTENDED)
      else $error("no extended");
   hold_proto_a: assert property ((!chip_select_n)[*6] |-> $stable(protocol))
      else $error("protocol moved in frame");
   oe_off_a: assert property (chip_select_n |-> lane_oe == 4'h0)
      else $error("lanes driven while deselected");
   lane2_idle_a: assert property (chip_select_n[*4] |-> !lane2_is_data)
      else $error("lane2 data while deselected");
   quad_pins_a: assert property ((protocol == SFL_QUAD && !chip_select_n)[*5] |->
      !pause_enable && !protect_freeze) else $error("pins active in quad frame");
   boost_off_a: assert property (clock_enable && last_data_in && enhanced_volatile_config[3]
      |=> op_start && !op_boosted) else $error("unboosted start late");
   boost_cause_a: assert property (op_start && op_boosted |->
      !enhanced_volatile_config[3] && boost_supply_high) else $error("boost without cause");

   cov_write_c: cover property (started && evcr_write);
   cov_rx_c: cover property (rx_valid);
   cov_boost_c: cover property (op_start && op_boosted);
   cov_quad_c: cover property (protocol == SFL_QUAD && !chip_select_n);
endmodule

bind sfl_lane_select sfl_lane_select_asserts chk (.clock, .rst, .clock_enable, .chip_select_n,
   .lane_oe, .boost_supply_high, .evcr_write, .evcr_data, .enhanced_volatile_config,
   .last_data_in, .rx_valid, .protocol, .pause_enable, .protect_freeze, .lane2_is_data,
   .op_start, .op_boosted);

// file: verification/sfl_spi_master.sv
`timescale 1ns/1ps

// spi master on the far side; also resolves the four lane wires
module sfl_spi_master (
   // device drive
   input  wire logic [3:0] lane_out,
   input  wire logic [3:0] lane_oe,
   input  wire logic       protect_level,
   // wires seen by the device
   output logic      [3:0] lane_in,
   output logic            spi_clk,
   output logic            chip_select_n
);
   logic [3:0] drv;    // master drive values
   logic [3:0] drv_en; // master drive enables
   logic       cpol;   // idle clock level, mode 0 or mode 3
   initial begin
      spi_clk = 1'b0;
      chip_select_n = 1'b1;
      drv = 4'h0;
      drv_en = 4'h0;
      cpol = 1'b0;
   end

   // released data lanes float, so show the inverse of the last drive;
   // lane 2 follows the protect level, the pause pin has a pull-up
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lane_in[i] = lane_oe[i] ? lane_out[i] : drv_en[i] ? drv[i] :
                      (i == 2) ? protect_level : (i == 3) ? 1'b1 : ~drv[i];
      end
   end

   // select with the clock at its idle level; clock stands still outside frames
   task automatic frame_start(input logic mode3);
      cpol = mode3;
      #3 spi_clk = mode3; // keeps the link edges off the core clock's edges
      #40 chip_select_n = 1'b0;
      #40 spi_clk = 1'b0;
   endtask

   task automatic frame_end();
      drv_en = 4'h0;
      // deselect before the clock returns to idle: no extra rising edge in mode 3
      #43 chip_select_n = 1'b1;
      #40 spi_clk = cpol;
   endtask

   // msb first on 1, 2 or 4 lanes; lanes 0 only listens on lane 1 for 16 beats
   task automatic shift_byte(input logic [7:0] tx, input int lanes, output logic [15:0] seen);
      logic [7:0] w;
      #3;
      for (int i = 0; i < ((lanes == 0) ? 16 : 8 / lanes); i++) begin
         w = tx << (i * lanes);
         drv_en = (lanes == 4) ? 4'hf : (lanes == 2) ? 4'h3 : {3'h0, lanes == 1};
         drv = (lanes == 4) ? w[7:4] : (lanes == 2) ? {2'h0, w[7:6]} : {3'h0, w[7]};
         #40 seen = {seen[14:0], lane_in[1]};
         spi_clk = 1'b1; // device samples here
         #40 spi_clk = 1'b0;
      end
   endtask
endmodule

// file: verification/sfl_lane_select_tb.sv
`timescale 1ns/1ps

module sfl_lane_select_tb;
   import sfl_pkg::*;
   localparam int BW = 50; // short boost wait for simulation
   logic clock, rst, clock_enable, spi_clk, chip_select_n, boost_supply_high, evcr_write;
   logic [3:0] lane_in, lane_out, lane_oe;
   logic [15:0] nonvolatile_config, seen;
   logic [7:0] evcr_data, enhanced_volatile_config, tx_byte, rx_byte;
   logic [2:0] data_lane_count;
   logic quad_output_read_cmd, quad_io_read_cmd, quad_input_program_cmd, last_data_in;
   logic quad_input_ext_program_cmd, quad_modify_cmd, write_in_progress_flag, tx_active;
   logic tx_taken, rx_valid, rx_is_instr, protect_freeze, pause_enable, lane2_is_data;
   logic op_start, op_boosted, protect_level;
   sfl_protocol_t protocol;
   logic [8:0] rxq[$]; // received bytes, instruction flag on top
   int n_errors, num_checks, n, n_taken;

   sfl_lane_select #(.BOOST_WAIT_CYCLES(BW)) dut (.clock, .rst, .clock_enable, .spi_clk,
      .chip_select_n, .lane_in, .lane_out, .lane_oe, .boost_supply_high, .nonvolatile_config,
      .evcr_write, .evcr_data, .enhanced_volatile_config, .data_lane_count,
      .quad_output_read_cmd, .quad_io_read_cmd, .quad_input_program_cmd,
      .quad_input_ext_program_cmd, .quad_modify_cmd, .last_data_in, .write_in_progress_flag,
      .tx_active, .tx_byte, .tx_taken, .rx_byte, .rx_valid, .rx_is_instr, .protocol,
      .protect_freeze, .pause_enable, .lane2_is_data, .op_start, .op_boosted);
   sfl_spi_master master (.lane_out, .lane_oe, .protect_level, .lane_in, .spi_clk,
      .chip_select_n);

   always #5 clock = ~clock;
   always @(posedge clock) begin
      if (rx_valid === 1'b1) begin
         rxq.push_back({rx_is_instr, rx_byte});
      end
      if (tx_taken === 1'b1) begin
         n_taken++;
      end
   end

   task automatic finish_test();
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clock);
   endtask

   task automatic do_reset(input logic [15:0] nv);
      nonvolatile_config <= nv;
      rst <= 1'b1;
      idle(10);
      rst <= 1'b0;
      idle(6);
   endtask

   task automatic write_evcr(input logic [7:0] v);
      evcr_write <= 1'b1;
      evcr_data <= v;
      idle(1);
      evcr_write <= 1'b0;
      idle(8);
   endtask

   // bounded wait for one received byte
   task automatic expect_rx(input logic [8:0] exp);
      for (n = 0; rxq.size() == 0 && n < 40; n++) idle(1);
      if (rxq.size() == 0) begin
         n_errors++;
         finish_test();
      end
      check("rx byte", {7'h0, rxq.pop_front()}, {7'h0, exp});
   endtask

   // pulse last data in and count cycles until the start pulse
   task automatic start_op();
      last_data_in <= 1'b1;
      idle(1);
      last_data_in <= 1'b0;
      for (n = 1; n < 200; n++) begin
         @(negedge clock);
         if (op_start === 1'b1) break;
      end
      if (n == 200) begin
         n_errors++;
         finish_test();
      end
      idle(1);
   endtask

   task automatic t_power_on();
      logic [15:0] nv[4] = '{16'hffff, 16'hfffb, 16'hfff7, 16'hfff3};
      logic [1:0] pr[4] = '{SFL_EXTENDED, SFL_DUAL, SFL_QUAD, SFL_QUAD};
      logic [7:0] ev[4] = '{8'hff, 8'hbf, 8'h7f, 8'h3f};
      for (int i = 3; i >= 0; i--) begin
         do_reset(nv[i]);
         check("evcr", {8'h0, enhanced_volatile_config}, {8'h0, ev[i]});
         check("protocol", {14'h0, protocol}, {14'h0, pr[i]});
      end
   endtask

   task automatic t_extended();
      data_lane_count <= 3'h4;
      quad_output_read_cmd <= 1'b1;
      idle(1);
      master.frame_start(1'b0);
      master.shift_byte(8'ha5, 1, seen);
      check("lane2", {15'h0, lane2_is_data}, 16'h1);
      master.shift_byte(8'h3c, 4, seen);
      master.frame_end();
      quad_output_read_cmd <= 1'b0;
      expect_rx({1'b1, 8'ha5});
      expect_rx({1'b0, 8'h3c});
   endtask

   task automatic t_dual();
      write_evcr(8'hbf);
      check("dual", {14'h0, protocol}, {14'h0, SFL_DUAL});
      clock_enable <= 1'b0;
      write_evcr(8'h7f);
      check("frozen", {8'h0, enhanced_volatile_config}, 16'hbf);
      clock_enable <= 1'b1;
      master.frame_start(1'b1);
      master.shift_byte(8'h96, 2, seen);
      master.frame_end();
      expect_rx({1'b1, 8'h96});
   endtask

   task automatic t_quad();
      write_evcr(8'h3f);
      check("quad", {14'h0, protocol}, {14'h0, SFL_QUAD});
      master.frame_start(1'b0);
      master.shift_byte(8'h5a, 4, seen);
      idle(1);
      check("pins", {pause_enable, lane2_is_data}, 16'h1);
      write_evcr(8'hff);
      check("held", {14'h0, protocol}, {14'h0, SFL_QUAD});
      master.shift_byte(8'hc3, 4, seen);
      master.frame_end();
      expect_rx({1'b1, 8'h5a});
      expect_rx({1'b0, 8'hc3});
      idle(8);
      check("after", {14'h0, protocol}, {14'h0, SFL_EXTENDED});
   endtask

   task automatic t_boost();
      write_evcr(8'hf7);
      quad_input_program_cmd <= 1'b1;
      start_op();
      check("wait", {15'h0, n >= BW}, 16'h1);
      check("slow", {15'h0, op_boosted}, 16'h0);
      quad_input_program_cmd <= 1'b0;
      quad_modify_cmd <= 1'b1;
      boost_supply_high <= 1'b1;
      start_op();
      check("fast", {15'h0, n < 10 && op_boosted === 1'b1}, 16'h1);
      boost_supply_high <= 1'b0;
      write_evcr(8'hff);
      start_op();
      check("off", {15'h0, n <= 2 && op_boosted === 1'b0}, 16'h1);
      quad_modify_cmd <= 1'b0;
      write_evcr(8'h77);
      boost_supply_high <= 1'b1;
      write_in_progress_flag <= 1'b1;
      idle(10);
      check("fallback", {14'h0, protocol}, {14'h0, SFL_EXTENDED});
      boost_supply_high <= 1'b0;
      idle(10);
      check("return", {14'h0, protocol}, {14'h0, SFL_QUAD});
      write_in_progress_flag <= 1'b0;
      write_evcr(8'hff);
   endtask

   task automatic t_protect_tx();
      int taken0;
      protect_level <= 1'b0;
      idle(8);
      check("freeze", {15'h0, protect_freeze}, 16'h1);
      protect_level <= 1'b1;
      idle(8);
      check("thaw", {15'h0, protect_freeze}, 16'h0);
      tx_byte <= 8'h6d;
      tx_active <= 1'b1;
      taken0 = n_taken;
      master.frame_start(1'b0);
      master.shift_byte(8'h00, 0, seen);
      master.frame_end();
      tx_active <= 1'b0;
      // first beat sees the idle line, then the byte msb first on lane 1
      check("tx", {8'h0, seen[14:7]}, 16'h6d);
      check("taken", 16'(n_taken - taken0), 16'h2);
      check("oe", {12'h0, lane_oe}, 16'h0);
   endtask

   initial begin
      clock = 1'b0;
      clock_enable = 1'b1;
      {boost_supply_high, evcr_write, evcr_data, data_lane_count, tx_active, tx_byte} = '0;
      {quad_output_read_cmd, quad_io_read_cmd, quad_input_program_cmd} = '0;
      {quad_input_ext_program_cmd, quad_modify_cmd, last_data_in, write_in_progress_flag} = '0;
      protect_level = 1'b1;
      t_power_on();
      t_extended();
      t_dual();
      t_quad();
      t_boost();
      t_protect_tx();
      finish_test();
   end
endmodule
